// ==== src/oledc_top.sv ====
// oledc_top: command decoder, display ram, clock divider and row/column scan
// assumes the host strobes one command or data byte per write, inputs synchronous to clk_i
// Contract
// R1: 92h assigns colours to banks 1-16
// R2: 93h assigns colours to banks 17-32
// R3: column remap affects only later writes
// R4: A5h lights all, A4h follows ram
// R5: A7h inverts pixel sense, A6h normal
// R6: mux ratio 16..64 rows, default 64
// R7: three display states: dim, off, on
// R8: off turns drivers to high impedance
// R9: on enables circuits from master config
// R10: dim state uses its own contrast, brightness
// R11: B0h-B7h load page pointer
// R12: scan direction flips rows immediately
// R13: D3h maps start line onto row output
// R14: host writes 64-N to shift back
// R15: low nibble sets divide ratio 1..16
// R16: high nibble sets oscillator, reset 0111
// R17: internal oscillator only when select high
// R18: start line picks ram row on row0
// R19: colour widths 32..64, D fixed 64
// R20: settings applied after last parameter byte
// R21: rows past mux ratio stay dark; code lets a row above a lowered ratio finish its 64 display clocks first
`timescale 1ns/10ps
module oledc_top
  import oledc_pkg::*;
(
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rstn_i,
  // host byte port
  input  wire logic [1:0]         addr_i,
  input  wire logic [7:0]         wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic      [7:0]         rdata_o,
  // clock source
  input  wire logic               internal_clock_select_i,
  input  wire logic               ext_clk_tick_i,
  // panel side
  output oledc_pkg::oledc_panel_t panel_o,
  output logic      [7:0]         contrast_o,
  output logic      [7:0]         bright_o,
  output logic                    circuits_on_o,
  output logic                    ext_supply_o,
  output logic                    display_clock_o
);
  import oledc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [2:0] param_count(input logic [7:0] op);
    unique case (op)
      OP_LUT, OP_BANK_LO, OP_BANK_HI: param_count = 3'd4;
      OP_DIM_SET:                     param_count = 3'd2;
      OP_CONTRAST, OP_BRIGHT, OP_MUX, OP_MASTER, OP_OFFSET, OP_CLOCK: param_count = 3'd1;
      default:                        param_count = 3'd0;
    endcase
  endfunction

  // width codes below the floor clamp to 32 display clocks
  function automatic logic [6:0] lut_width(input logic [5:0] v);
    lut_width = (v < LUT_MIN_CODE) ? PW_MIN : ({1'b0, v} + 7'd1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // command decoder
  oledc_cfg_t  cfg, next_cfg;
  oledc_cmd_t  cs, next_cs;
  logic [7:0]  op, next_op;
  logic [2:0]  cnt, next_cnt;
  logic [23:0] pbuf, next_pbuf;
  logic [7:0]  rdata, next_rdata;
  logic [31:0] full;
  logic [7:0]  pcol;
  logic [5:0]  row;

  assign full = {pbuf, wdata_i};
  // R3: physical column fixed at write time
  assign pcol = cfg.seg_remap ? (COL_LAST - cfg.column) : cfg.column;

  always_comb
  begin
    next_cfg   = cfg;
    next_cs    = cs;
    next_op    = op;
    next_cnt   = cnt;
    next_pbuf  = pbuf;
    next_rdata = 8'h00;
    if (rd_i)
    begin
      unique case (addr_i)
        ADDR_STAT: next_rdata = {3'b000, cfg.scan_rev, cfg.inverse, cfg.all_on, cfg.disp};
        ADDR_SCAN: next_rdata = {2'b00, row};
        default:   next_rdata = 8'h00;
      endcase
    end
    if (wr_i && addr_i == ADDR_DATA)
      next_cfg.column = (cfg.column == COL_LAST) ? 8'h00 : cfg.column + 8'd1;
    if (wr_i && addr_i == ADDR_CMD)
    begin
      unique case (cs)
        CS_OP:
        begin
          if (param_count(wdata_i) != 3'd0)
          begin
            next_cs  = CS_PARAM;
            next_op  = wdata_i;
            next_cnt = param_count(wdata_i);
          end
          else if (wdata_i[7:3] == OP_PAGE_HI5)
            // R11: page from opcode low bits
            next_cfg.page = wdata_i[2:0];
          else if (wdata_i[7:6] == OP_START_HI)
            // R18: start line load
            next_cfg.start = wdata_i[5:0];
          else if (wdata_i[7:4] == OP_COL_LO)
            next_cfg.column[3:0] = wdata_i[3:0];
          else if (wdata_i[7:4] == OP_COL_HI)
            next_cfg.column[7:4] = wdata_i[3:0];
          else
          begin
            unique case (wdata_i)
              // R3: remap select
              OP_REMAP0:   next_cfg.seg_remap = 1'b0;
              OP_REMAP1:   next_cfg.seg_remap = 1'b1;
              // R4: all-on select
              OP_RAM_SHOW: next_cfg.all_on = 1'b0;
              OP_ALL_ON:   next_cfg.all_on = 1'b1;
              // R5: inverse select
              OP_NORMAL:   next_cfg.inverse = 1'b0;
              OP_INVERSE:  next_cfg.inverse = 1'b1;
              // R7: display state
              OP_DIM_ON:   next_cfg.disp = DS_DIM;
              OP_OFF:      next_cfg.disp = DS_OFF;
              OP_ON:       next_cfg.disp = DS_ON;
              // R12: scan direction
              OP_SCAN_FWD: next_cfg.scan_rev = 1'b0;
              OP_SCAN_REV: next_cfg.scan_rev = 1'b1;
              default:     next_cfg = cfg;
            endcase
          end
        end
        CS_PARAM:
        begin
          next_pbuf = full[23:0];
          next_cnt  = cnt - 3'd1;
          // R20: apply on final byte
          if (cnt == 3'd1)
          begin
            next_cs = CS_OP;
            unique case (op)
              OP_CONTRAST: next_cfg.contrast = wdata_i;
              OP_BRIGHT:   next_cfg.bright = wdata_i;
              // R19: base, A, B, C widths
              OP_LUT:      next_cfg.lut = {full[29:24], full[21:16], full[13:8], full[5:0]};
              // R1: banks 1-16, first byte lowest
              OP_BANK_LO:  next_cfg.bank[31:0] = {full[7:0], full[15:8], full[23:16], full[31:24]};
              // R2: banks 17-32
              OP_BANK_HI:  next_cfg.bank[63:32] = {full[7:0], full[15:8], full[23:16], full[31:24]};
              // R6: ratio below 16 ignored
              OP_MUX:      if (wdata_i[5:0] >= MUX_MIN) next_cfg.mux = wdata_i[5:0];
              // R10: dim contrast and brightness
              OP_DIM_SET:  {next_cfg.dim_contrast, next_cfg.dim_bright} = full[15:0];
              OP_MASTER:   next_cfg.master = wdata_i;
              // R13: 6-bit offset
              OP_OFFSET:   next_cfg.offset = wdata_i[5:0];
              // R15: divide ratio R16: oscillator
              OP_CLOCK:    {next_cfg.osc, next_cfg.div} = wdata_i;
              default:     next_cfg = cfg;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cfg   <= CFG_RST;
      cs    <= CS_OP;
      op    <= 8'h00;
      cnt   <= 3'd0;
      pbuf  <= 24'h0;
      rdata <= 8'h00;
    end
    else
    begin
      cfg   <= next_cfg;
      cs    <= next_cs;
      op    <= next_op;
      cnt   <= next_cnt;
      pbuf  <= next_pbuf;
      rdata <= next_rdata;
    end
  end
  assign rdata_o = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // display ram, page addressing writes; no reset, contents undefined at power-up
  logic [131:0] ram [64];
  always_ff @(posedge clk_i)
  begin
    if (wr_i && addr_i == ADDR_DATA && pcol <= COL_LAST)
      for (int i = 0; i < 8; i++)
        ram[{cfg.page, i[2:0]}][pcol] <= wdata_i[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock source, divider and row scan
  logic [4:0] osc_cnt, next_osc_cnt;
  logic [3:0] div_cnt, next_div_cnt;
  logic [5:0] pw_cnt, next_pw_cnt;
  logic [5:0] next_row;
  logic       display_clock, next_display_clock;
  logic       src_tick;

  // R17: source follows the select pin
  assign src_tick = internal_clock_select_i ? (osc_cnt == 5'd0) : ext_clk_tick_i;

  always_comb
  begin
    next_osc_cnt = (osc_cnt == 5'd0) ? (OSC_BASE_CYC - {1'b0, cfg.osc}) : osc_cnt - 5'd1;
    next_div_cnt = div_cnt;
    next_display_clock    = 1'b0;
    next_pw_cnt  = pw_cnt;
    next_row     = row;
    if (src_tick)
    begin
      // R15: one display clock per div+1 source ticks
      if (div_cnt >= cfg.div)
      begin
        next_div_cnt = 4'h0;
        next_display_clock    = 1'b1;
      end
      else
        next_div_cnt = div_cnt + 4'h1;
    end
    if (display_clock)
    begin
      next_pw_cnt = pw_cnt + 6'd1;
      if (pw_cnt == PW_LAST)
        // R21: scan wraps to row 0 after the mux ratio row
        next_row = (row >= cfg.mux) ? 6'd0 : row + 6'd1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      osc_cnt <= 5'd0;
      div_cnt <= 4'h0;
      pw_cnt  <= 6'd0;
      row     <= 6'd0;
      display_clock    <= 1'b0;
    end
    else
    begin
      osc_cnt <= next_osc_cnt;
      div_cnt <= next_div_cnt;
      pw_cnt  <= next_pw_cnt;
      row     <= next_row;
      display_clock    <= next_display_clock;
    end
  end
  assign display_clock_o = display_clock;

  ////////////////////////////////////////////////////////////////////////////
  // panel drive
  oledc_panel_t panel, next_panel;
  logic [5:0]   ram_row;
  logic [131:0] ram_line;
  logic [131:0] lit;
  logic         on;

  // R18: start line wraps within 64 rows
  assign ram_row  = row + cfg.start;
  assign ram_line = ram[ram_row];
  assign on       = (cfg.disp != DS_OFF);

  for (genvar c = 0; c < NUM_COLS; c++)
  begin : g_col
    localparam int BANK = c / 4;
    logic [1:0] colour;
    logic [6:0] width;
    // base bank split off so no constant select falls below bit 0
    if (BANK == 0)
    begin : g_base
      assign colour = 2'd0;
      assign width  = lut_width(cfg.lut[23:18]);
    end
    else
    begin : g_area
      assign colour = cfg.bank[2 * (BANK - 1) +: 2];
      // R19: colour D fixed full width
      assign width  = (colour == COLOUR_D) ? PW_FULL : lut_width(cfg.lut[6 * (2 - colour) +: 6]);
    end
    // R4: all-on overrides ram R5: inverse sense
    assign lit[c] = (cfg.all_on | (ram_line[c] ^ cfg.inverse)) & ({1'b0, pw_cnt} < width);
  end

  always_comb
  begin
    next_panel          = panel;
    next_panel.col_data = on ? lit : 132'h0;
    // R12: immediate row order R13: offset R14: wrap modulo 64
    next_panel.row_sel  = (cfg.scan_rev ? (cfg.mux - row) : row) + cfg.offset;
    // R8: drivers released when off
    next_panel.col_oe   = on;
    next_panel.row_oe   = on;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      panel <= '0;
    else
      panel <= next_panel;
  end

  assign panel_o       = panel;
  // R10: dim values in dim state
  assign contrast_o    = (cfg.disp == DS_DIM) ? cfg.dim_contrast : cfg.contrast;
  assign bright_o      = (cfg.disp == DS_DIM) ? cfg.dim_bright : cfg.bright;
  // R9: circuits follow display state, external supply follows master config
  assign circuits_on_o = on;
  assign ext_supply_o  = on & ~cfg.master[0];
endmodule // oledc_top

// ==== src/oledc_pkg.sv ====
// oledc_pkg: constants, opcodes, state types and carriers of the display control block
// assumes a single 10 MHz clock domain and a byte-wide command port
package oledc_pkg;
  // bus map
  localparam logic [1:0] ADDR_CMD  = 2'h0;
  localparam logic [1:0] ADDR_DATA = 2'h1;
  localparam logic [1:0] ADDR_STAT = 2'h2;
  localparam logic [1:0] ADDR_SCAN = 2'h3;
  // opcodes
  localparam logic [7:0] OP_CONTRAST = 8'h81;
  localparam logic [7:0] OP_BRIGHT   = 8'h82;
  localparam logic [7:0] OP_LUT      = 8'h91;
  localparam logic [7:0] OP_BANK_LO  = 8'h92;
  localparam logic [7:0] OP_BANK_HI  = 8'h93;
  localparam logic [7:0] OP_REMAP0   = 8'hA0;
  localparam logic [7:0] OP_REMAP1   = 8'hA1;
  localparam logic [7:0] OP_RAM_SHOW = 8'hA4;
  localparam logic [7:0] OP_ALL_ON   = 8'hA5;
  localparam logic [7:0] OP_NORMAL   = 8'hA6;
  localparam logic [7:0] OP_INVERSE  = 8'hA7;
  localparam logic [7:0] OP_MUX      = 8'hA8;
  localparam logic [7:0] OP_DIM_SET  = 8'hAB;
  localparam logic [7:0] OP_DIM_ON   = 8'hAC;
  localparam logic [7:0] OP_MASTER   = 8'hAD;
  localparam logic [7:0] OP_OFF      = 8'hAE;
  localparam logic [7:0] OP_ON       = 8'hAF;
  localparam logic [7:0] OP_SCAN_FWD = 8'hC0;
  localparam logic [7:0] OP_SCAN_REV = 8'hC8;
  localparam logic [7:0] OP_OFFSET   = 8'hD3;
  localparam logic [7:0] OP_CLOCK    = 8'hD5;
  localparam logic [4:0] OP_PAGE_HI5 = 5'h16;
  localparam logic [1:0] OP_START_HI = 2'h1;
  localparam logic [3:0] OP_COL_LO   = 4'h0;
  localparam logic [3:0] OP_COL_HI   = 4'h1;
  // geometry and timing
  localparam int         NUM_COLS     = 132;
  localparam logic [7:0] COL_LAST     = 8'd131;
  localparam logic [5:0] MUX_MIN      = 6'd15;
  localparam logic [5:0] PW_LAST      = 6'd63;
  localparam logic [6:0] PW_MIN       = 7'd32;
  localparam logic [6:0] PW_FULL      = 7'd64;
  localparam logic [5:0] LUT_MIN_CODE = 6'd31;
  localparam logic [4:0] OSC_BASE_CYC = 5'd20;
  localparam logic [1:0] COLOUR_D     = 2'd3;
  // reset values
  localparam logic [5:0] MUX_RST      = 6'd63;
  localparam logic [3:0] DIV_RST      = 4'h0;
  localparam logic [3:0] OSC_RST      = 4'h7;
  localparam logic [7:0] CONTRAST_RST = 8'h80;
  localparam logic [7:0] MASTER_RST   = 8'h00;
  localparam logic [5:0] LUT_RST      = 6'h3F;

  typedef enum logic [1:0] {DS_OFF = 2'b00, DS_DIM = 2'b01, DS_ON = 2'b10} oledc_disp_t;
  typedef enum logic {CS_OP = 1'b0, CS_PARAM = 1'b1} oledc_cmd_t;

  typedef struct packed {
    logic [63:0] bank;
    logic        seg_remap;
    logic        all_on;
    logic        inverse;
    logic [5:0]  mux;
    oledc_disp_t disp;
    logic [7:0]  master;
    logic [7:0]  contrast;
    logic [7:0]  bright;
    logic [7:0]  dim_contrast;
    logic [7:0]  dim_bright;
    logic [2:0]  page;
    logic [7:0]  column;
    logic        scan_rev;
    logic [5:0]  offset;
    logic [5:0]  start;
    logic [3:0]  div;
    logic [3:0]  osc;
    logic [23:0] lut;
  } oledc_cfg_t;

  localparam oledc_cfg_t CFG_RST = '{bank: 64'h0, seg_remap: 1'b0, all_on: 1'b0, inverse: 1'b0,
    mux: MUX_RST, disp: DS_OFF, master: MASTER_RST, contrast: CONTRAST_RST, bright: CONTRAST_RST,
    dim_contrast: CONTRAST_RST, dim_bright: CONTRAST_RST, page: 3'h0, column: 8'h00, scan_rev: 1'b0,
    offset: 6'h00, start: 6'h00, div: DIV_RST, osc: OSC_RST, lut: {4{LUT_RST}}};

  typedef struct packed {
    logic [131:0] col_data;
    logic         col_oe;
    logic [5:0]   row_sel;
    logic         row_oe;
  } oledc_panel_t;
endpackage

// ==== verification/oledc_top_props.sv ====
// oledc_top_props: port checks of the display control block
// assumes one clock domain; bound onto oledc_top at the foot
`timescale 1ns/10ps
module oledc_top_props
  import oledc_pkg::*;
(
  // clock and reset
  input wire logic                    clk_i,
  input wire logic                    rstn_i,
  // byte port
  input wire logic [1:0]              addr_i,
  input wire logic [7:0]              wdata_i,
  input wire logic                    wr_i,
  input wire logic                    rd_i,
  input wire logic [7:0]              rdata_o,
  // clock source
  input wire logic                    internal_clock_select_i,
  input wire logic                    ext_clk_tick_i,
  // panel side
  input wire oledc_pkg::oledc_panel_t panel_o,
  input wire logic [7:0]              contrast_o,
  input wire logic [7:0]              bright_o,
  input wire logic                    circuits_on_o,
  input wire logic                    ext_supply_o,
  input wire logic                    display_clock_o
);
  logic       op;
  logic [2:0] pend;
  logic [2:0] next_pend;
  logic [2:0] flg;
  logic [2:0] next_flg;
  logic [1:0] dsp;
  logic [1:0] next_dsp;
  // parameter bytes must not be taken for opcodes
  assign op = wr_i && addr_i == ADDR_CMD && pend == 3'h0;
  always_comb
  begin
    next_pend = pend;
    next_flg = flg;
    next_dsp = dsp;
    if (wr_i && addr_i == ADDR_CMD && !op)
      next_pend = pend - 3'h1;
    if (op)
    begin
      case (wdata_i)
        OP_CONTRAST, OP_BRIGHT, OP_MUX, OP_MASTER, OP_OFFSET, OP_CLOCK: next_pend = 3'h1;
        OP_DIM_SET: next_pend = 3'h2;
        OP_LUT, OP_BANK_LO, OP_BANK_HI: next_pend = 3'h4;
        OP_RAM_SHOW, OP_ALL_ON: next_flg[0] = wdata_i[0];
        OP_NORMAL, OP_INVERSE: next_flg[1] = wdata_i[0];
        OP_SCAN_FWD, OP_SCAN_REV: next_flg[2] = wdata_i[3];
        OP_DIM_ON: next_dsp = 2'h1;
        OP_OFF: next_dsp = 2'h0;
        OP_ON: next_dsp = 2'h2;
        default: next_pend = pend;
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      {pend, flg, dsp} <= 8'h00;
    else
      {pend, flg, dsp} <= {next_pend, next_flg, next_dsp};
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_off2;
    !circuits_on_o [*2];
  endsequence
  sequence s_no_src;
    (!internal_clock_select_i && !ext_clk_tick_i) [*3];
  endsequence
  sequence s_stat_rd;
    rd_i && addr_i == ADDR_STAT;
  endsequence
  a_ext_supply: assert property (ext_supply_o |-> circuits_on_o)
    else $error("supply enabled while display off");
  a_disp_state: assert property (circuits_on_o == (dsp != 2'h0))
    else $error("circuits do not follow display state");
  a_stat_disp: assert property (s_stat_rd |=> rdata_o[1:0] == $past(dsp))
    else $error("status shows wrong display state");
  a_stat_flags: assert property (s_stat_rd |=> rdata_o[4:2] == $past(flg))
    else $error("status shows wrong mode flags");
  a_off_hiz: assert property (s_off2 |-> !panel_o.col_oe && !panel_o.row_oe)
    else $error("drivers enabled while display off");
  a_contrast_cause: assert property (($changed(contrast_o) || $changed(bright_o)) |-> $past(wr_i))
    else $error("level changed without a write");
  a_no_source: assert property (s_no_src |-> !display_clock_o)
    else $error("display clock without a source tick");
  a_row_cause: assert property ($changed(panel_o.row_sel) |->
    $past(display_clock_o) || $past(display_clock_o, 2) || $past(wr_i) || $past(wr_i, 2))
    else $error("row output moved without cause");
endmodule // oledc_top_props

bind oledc_top oledc_top_props u_props (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .internal_clock_select_i(internal_clock_select_i),
  .ext_clk_tick_i(ext_clk_tick_i), .panel_o(panel_o), .contrast_o(contrast_o), .bright_o(bright_o),
  .circuits_on_o(circuits_on_o), .ext_supply_o(ext_supply_o), .display_clock_o(display_clock_o));

// ==== verification/oledc_host.sv ====
// oledc_host: host controller model on the command byte port
// assumes one bench process calls its tasks; ticks follow tick_en_i
`timescale 1ns/10ps
module oledc_host
  import oledc_pkg::*;
(
  // clock
  input  wire logic       clk_i,
  // byte port
  output logic      [1:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o,
  input  wire logic [7:0] rdata_i,
  // external source clock
  input  wire logic       tick_en_i,
  output logic            ext_tick_o
);
  initial
  begin
    addr_o = 2'h0;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    ext_tick_o = 1'b0;
  end
  always @(posedge clk_i)
    ext_tick_o <= tick_en_i;
  ////////////////////////////////////////
  // released lines show the inverse, so a stale byte is never read as held
  task automatic wr_byte(input logic [1:0] a, input logic [7:0] b);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= b;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~b;
    #1;
  endtask
  task automatic rd_byte(input logic [1:0] a, output logic [7:0] b);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    b = rdata_i;
  endtask
  // shift back by n: writes 64 minus n
  task automatic offset_back(input logic [5:0] n);
    wr_byte(ADDR_CMD, OP_OFFSET);
    wr_byte(ADDR_CMD, {2'h0, 6'h00 - n});
  endtask
endmodule // oledc_host

// ==== verification/tb_top.sv ====
// tb_top: self-checking bench of the display control block
// assumes the host model owns the byte port and the external tick
`timescale 1ns/10ps
module tb_top;
  import oledc_pkg::*;
  localparam logic [7:0] ST_OP [3] = '{OP_DIM_ON, OP_OFF, OP_ON};
  localparam logic [1:0] ST_EX [3] = '{2'h1, 2'h0, 2'h2};
  localparam logic [7:0] FL_OP [6] = '{OP_ALL_ON, OP_RAM_SHOW, OP_INVERSE, OP_NORMAL, OP_SCAN_REV, OP_SCAN_FWD};
  localparam logic [2:0] FL_EX [6] = '{3'h1, 3'h0, 3'h2, 3'h0, 3'h4, 3'h0};
  localparam logic [7:0] PRG [15] = '{OP_LUT, 8'h00, 8'h27, 8'h2F, 8'h37, OP_BANK_LO, 8'hE4, 8'h00, 8'h00,
    8'h00, OP_BANK_HI, 8'hE4, 8'h00, 8'h00, 8'h00};
  localparam int         COLS [7] = '{0, 4, 8, 12, 16, 68, 80};
  localparam int         WID [7] = '{32, 40, 48, 56, 64, 40, 64};
  localparam logic [7:0] CK_SET [5] = '{8'h7F, 8'h73, 8'h73, 8'h03, 8'hF0};
  localparam logic       CK_SEL [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  localparam int         CK_N [5] = '{160, 40, 560, 840, 60};
  logic         clk_i;
  logic         rstn_i;
  logic         int_sel;
  logic         tick_en;
  logic         ext_tick;
  logic [1:0]   addr;
  logic [7:0]   wdata;
  logic         wr;
  logic         rd;
  logic [7:0]   rdata;
  oledc_panel_t panel;
  logic [7:0]   contrast;
  logic [7:0]   bright;
  logic         circ;
  logic         ext_sup;
  logic         display_clock;
  logic [7:0]   d;
  int           err_count;
  int           n_tests;
  int           cyc;
  int           k;
  int           mx;
  oledc_host u_host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata),
    .tick_en_i(tick_en), .ext_tick_o(ext_tick));
  oledc_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .internal_clock_select_i(int_sel), .ext_clk_tick_i(ext_tick), .panel_o(panel),
    .contrast_o(contrast), .bright_o(bright), .circuits_on_o(circ), .ext_supply_o(ext_sup),
    .display_clock_o(display_clock));
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  ////////////////////////////////////////
  task automatic check(input logic [131:0] seen, input logic [131:0] want);
    n_tests++;
    if (seen !== want)
    begin
      err_count++;
      $display("BAD t=%0t seen=%0h want=%0h", $time, seen, want);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] b);
    u_host.wr_byte(ADDR_CMD, b);
  endtask
  // counts cycles with the display clock (col < 0) or a column lit
  task automatic cnt(input int col, input int n, output int c);
    c = 0;
    repeat (n)
    begin
      @(posedge clk_i);
      #1;
      if ((col < 0 ? display_clock : panel.col_data[col]) === 1'b1)
        c++;
    end
  endtask
  // hang guard: the full sequence needs about 4700 cycles
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      wrap_up();
    end
  end
  ////////////////////////////////////////
  initial
  begin
    err_count = 0;
    n_tests = 0;
    cyc = 0;
    rstn_i = 1'b0;
    int_sel = 1'b0;
    tick_en = 1'b1;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    u_host.rd_byte(ADDR_STAT, d);
    check(d, 8'h00);
    check({contrast, panel.col_oe, panel.row_oe, circ}, {CONTRAST_RST, 3'h0});
    cnt(-1, 64, k);
    check(k, 64);
    // reset oscillator setting 0111 gives a 14-cycle source tick
    @(posedge clk_i);
    int_sel <= 1'b1;
    repeat (30) @(posedge clk_i);
    cnt(-1, 140, k);
    check(k, 10);
    @(posedge clk_i);
    int_sel <= 1'b0;
    foreach (ST_OP[i])
    begin
      cmd(ST_OP[i]);
      u_host.rd_byte(ADDR_STAT, d);
      check(d[1:0], ST_EX[i]);
      check({circ, ext_sup, panel.col_oe, panel.row_oe}, {4{ST_EX[i] != 2'h0}});
    end
    cmd(OP_MASTER);
    cmd(8'h01);
    check({circ, ext_sup}, 2'h2);
    foreach (FL_OP[i])
    begin
      cmd(FL_OP[i]);
      u_host.rd_byte(ADDR_STAT, d);
      check(d[4:2], FL_EX[i]);
    end
    cmd(OP_CONTRAST);
    cmd(8'h33);
    cmd(OP_DIM_ON);
    cmd(OP_DIM_SET);
    cmd(8'h11);
    check({contrast, bright}, {2{CONTRAST_RST}});
    cmd(8'h22);
    check({contrast, bright}, 16'h1122);
    cmd(OP_ON);
    check({contrast, bright}, {8'h33, CONTRAST_RST});
    cmd(OP_ALL_ON);
    foreach (PRG[i])
      cmd(PRG[i]);
    repeat (64) @(posedge clk_i);
    foreach (COLS[i])
    begin
      cnt(COLS[i], 64, k);
      check(k, WID[i]);
    end
    foreach (CK_SET[i])
    begin
      @(posedge clk_i);
      int_sel <= CK_SEL[i];
      cmd(OP_CLOCK);
      cmd(CK_SET[i]);
      repeat (100) @(posedge clk_i);
      cnt(-1, CK_N[i], k);
      check(k, 10);
    end
    @(posedge clk_i);
    int_sel <= 1'b0;
    tick_en <= 1'b0;
    // the last external tick is still in flight for two edges
    repeat (2) @(posedge clk_i);
    cnt(-1, 100, k);
    check(k, 0);
    tick_en <= 1'b1;
    cmd(OP_MUX);
    cmd(8'h0F);
    cmd(OP_MUX);
    cmd(8'h05);
    // let a row left above the new ratio wrap back first
    repeat (80) @(posedge clk_i);
    mx = 0;
    repeat (700)
    begin
      u_host.rd_byte(ADDR_SCAN, d);
      if (int'(d) > mx)
        mx = int'(d);
    end
    check(mx, 15);
    @(posedge clk_i);
    int_sel <= 1'b1;
    cmd(OP_CLOCK);
    cmd(8'h7F);
    cmd(OP_OFFSET);
    cmd(8'h08);
    u_host.rd_byte(ADDR_SCAN, d);
    check(panel.row_sel, 6'(d[5:0] + 6'h08));
    u_host.offset_back(6'h08);
    u_host.rd_byte(ADDR_SCAN, d);
    check(panel.row_sel, 6'(d[5:0] + 6'h38));
    cmd(OP_SCAN_REV);
    u_host.rd_byte(ADDR_SCAN, d);
    check(panel.row_sel, 6'(6'h0F - d[5:0] + 6'h38));
    // ram path: page 2, column 16 plain, column 51 remapped onto 80
    cmd(OP_RAM_SHOW);
    cmd(8'hB2);
    cmd(8'h11);
    cmd(8'h00);
    u_host.wr_byte(ADDR_DATA, 8'h01);
    cmd(OP_REMAP1);
    cmd(8'h13);
    cmd(8'h03);
    u_host.wr_byte(ADDR_DATA, 8'h01);
    u_host.rd_byte(ADDR_SCAN, d);
    cmd({2'h1, 6'(6'd16 - d[5:0])});
    u_host.rd_byte(ADDR_STAT, d);
    check({panel.col_data[16], panel.col_data[80]}, 2'h3);
    cmd(OP_INVERSE);
    u_host.rd_byte(ADDR_STAT, d);
    check({panel.col_data[16], panel.col_data[80]}, 2'h0);
    wrap_up();
  end
endmodule // tb_top
